// File: verilog/dc_brake_defines.svh
/*
 * constants for the dc brake and stop sequencer: parameter ids, field
 * positions, reset values and timing counts.
 * assumes a 10 MHz mclk and parameter ids taken as the register addresses.
 */
// How it works
// - brake drives DC instead of rotating waveform
// - hold brake for set time, max ten seconds
// - brake voltage is percent of rated voltage
// - ramp stop brakes at activation frequency
// - coast stop brakes at once, ignoring frequency
// - stop mode: one ramps, zero coasts
// - function code: off, stop, start, both
// - brake before start stops a spinning motor
// - activation frequency limited to max frequency
`ifndef DC_BRAKE_DEFINES_SVH
`define DC_BRAKE_DEFINES_SVH

// register ids
`define ID_STOP_BEHAVIOUR 8'h85
`define ID_BRAKE_FUNCTION 8'h99
`define ID_BRAKE_DURATION 8'h9a
`define ID_BRAKE_VOLTAGE 8'h9b
`define ID_BRAKE_ACT_FREQ 8'h9c

// reset values
`define RST_STOP_BEHAVIOUR 1'h1
`define RST_BRAKE_FUNCTION 2'h0
`define RST_BRAKE_DURATION 16'h0000
`define RST_BRAKE_VOLTAGE 16'h0000
`define RST_BRAKE_ACT_FREQ 16'h0000

// function code bits
`define FN_ON_STOP_BIT 0
`define FN_BEFORE_START_BIT 1

// limits: duration in tenths of a second, voltage in whole percent
`define BRAKE_TIME_MAX_TENTHS 16'h0064
`define BRAKE_PCT_MAX 16'h0064
`define PCT_DIVISOR 32'h0000_0064

// timing: one duration unit is 100 ms
`define MCLK_HZ 10000000
`define TENTH_MS 100
`define TENTH_CYCLES ((`MCLK_HZ / 1000) * `TENTH_MS)

`endif

// File: verilog/dc_brake_pkg.sv
/*
 * types for the dc brake and stop sequencer.
 * assumes nothing beyond a standard systemverilog compiler.
 */
package dc_brake_pkg;

	// sequencer states, gray along idle -> pre brake -> run -> ramp -> brake
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h0,
		ST_PRE_BRAKE = 3'h1,
		ST_RUN = 3'h3,
		ST_RAMP = 3'h2,
		ST_STOP_BRAKE = 3'h6
	} seq_state_t;

	// stop behaviour setting
	typedef enum logic
	{
		STOP_COAST = 1'h0,
		STOP_RAMP = 1'h1
	} stop_mode_t;

endpackage : dc_brake_pkg

// File: verilog/brake_timer_if.sv
/*
 * carrier between the sequencer and its brake duration timer.
 * assumes both ends run on the same mclk.
 */
`timescale 1ns/100ps
interface brake_timer_if;
	logic start; // one-cycle pulse, loads duration
	logic [15:0] tenths; // duration in tenths, already clamped
	logic done; // one-cycle pulse at expiry
	logic busy; // level while counting

	modport ctl (output start, output tenths, input done, input busy);
	modport tmr (input start, input tenths, output done, output busy);
endinterface : brake_timer_if

// File: verilog/brake_timer.sv
/*
 * brake duration timer: counts tenths of a second after a start pulse.
 * assumes start only while idle; a zero duration expires on the next edge.
 */
`timescale 1ns/100ps
`include "dc_brake_defines.svh"
module brake_timer #(
	parameter int TICK_CYCLES = `TENTH_CYCLES
)(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// link to sequencer
	brake_timer_if.tmr tif
);
	logic [31:0] tick_ff; // cycles within one tenth
	logic [15:0] left_ff; // tenths remaining
	logic busy_ff; // counting
	logic done_ff; // expiry pulse

	////////////////////////////////////////////////////////////////////////
	// countdown; zero duration still gives one done pulse
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tick_ff <= 32'h0;
			left_ff <= 16'h0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			if (tif.start)
			begin
				tick_ff <= 32'h0;
				left_ff <= tif.tenths;
				busy_ff <= 1'b1;
			end
			else if (busy_ff)
			begin
				if (left_ff == 16'h0)
				begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
				else if (tick_ff == 32'(TICK_CYCLES - 1))
				begin
					tick_ff <= 32'h0;
					left_ff <= left_ff - 16'h1;
				end
				else
					tick_ff <= tick_ff + 32'h1;
			end
		end
	end

	assign tif.done = done_ff;
	assign tif.busy = busy_ff;

	// done never fires unless the count had run out
	property p_done_at_zero;
		@(posedge mclk) disable iff (sys_rst)
		tif.done |-> $past(busy_ff) && ($past(left_ff) == 16'h0);
	endproperty
	a_done_at_zero: assert property (p_done_at_zero) else $error("timer done early");

endmodule : brake_timer

// File: verilog/dc_brake_seq.sv
/*
 * dc brake and stop sequencer: run/stop control, ramp down, dc injection
 * before start and on stop, with its parameter registers.
 * assumes run inputs are asynchronous pins; rated voltage, max frequency,
 * set frequency come from the drive core on mclk.
 */
`timescale 1ns/100ps
`include "dc_brake_defines.svh"
module dc_brake_seq
	import dc_brake_pkg::*;
#(
	parameter int TICK_CYCLES = `TENTH_CYCLES,
	parameter int RAMP_CYCLES = 16
)(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// run pins
	input wire logic run_clockwise,
	input wire logic run_counterclockwise,
	// drive core values
	input wire logic [15:0] rated_voltage,
	input wire logic [15:0] max_frequency,
	input wire logic [15:0] set_frequency,
	// parameter access
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// output stage
	output logic output_on,
	output logic dc_inject,
	output logic [15:0] out_frequency,
	output logic [15:0] brake_voltage,
	output logic [2:0] seq_state
);
	import dc_brake_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [1:0] cw_sync_ff; // pin synchroniser
	logic [1:0] ccw_sync_ff; // pin synchroniser
	logic run_cmd; // exactly one direction asked
	stop_mode_t stop_mode_ff; // stop behaviour
	logic [1:0] brake_fn_ff; // brake function code
	logic [15:0] brake_dur_ff; // duration, tenths
	logic [15:0] brake_pct_ff; // voltage percent
	logic [15:0] act_freq_ff; // activation frequency
	logic [15:0] dur_clamped; // duration held to ten seconds
	logic [15:0] pct_clamped; // percent held to full
	logic [15:0] act_clamped; // activation held to max frequency
	logic [31:0] volt_prod; // rated times percent
	seq_state_t state_ff; // sequencer state
	seq_state_t nxt_state;
	logic [15:0] freq_ff; // output frequency
	logic [15:0] nxt_freq;
	logic [15:0] ramp_cnt_ff; // cycles between frequency steps
	logic ramp_tick; // step now
	logic [15:0] bvolt_ff; // registered brake voltage
	logic [15:0] rdata_ff; // read data
	logic brake_on_stop; // function has stop braking
	logic brake_pre_start; // function has start braking
	logic start_timer; // load timer this cycle

	brake_timer_if tif ();

	brake_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.tif(tif)
	);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: only the second stage feeds logic
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cw_sync_ff <= 2'h0;
			ccw_sync_ff <= 2'h0;
		end
		else
		begin
			cw_sync_ff <= {cw_sync_ff[0], run_clockwise};
			ccw_sync_ff <= {ccw_sync_ff[0], run_counterclockwise};
		end
	end

	// both directions at once counts as no enable
	assign run_cmd = cw_sync_ff[1] ^ ccw_sync_ff[1];

	////////////////////////////////////////////////////////////////////////
	// parameter registers, writes take effect at once
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stop_mode_ff <= stop_mode_t'(`RST_STOP_BEHAVIOUR);
			brake_fn_ff <= `RST_BRAKE_FUNCTION;
			brake_dur_ff <= `RST_BRAKE_DURATION;
			brake_pct_ff <= `RST_BRAKE_VOLTAGE;
			act_freq_ff <= `RST_BRAKE_ACT_FREQ;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				`ID_STOP_BEHAVIOUR: stop_mode_ff <= stop_mode_t'(reg_wdata[0]);
				`ID_BRAKE_FUNCTION: brake_fn_ff <= reg_wdata[1:0];
				`ID_BRAKE_DURATION: brake_dur_ff <= reg_wdata;
				`ID_BRAKE_VOLTAGE: brake_pct_ff <= reg_wdata;
				`ID_BRAKE_ACT_FREQ: act_freq_ff <= reg_wdata;
				default: ; // unmapped writes dropped
			endcase
		end
	end

	// read data: stored values, unmapped ids read zero
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			rdata_ff <= 16'h0;
		else
		begin
			unique case (reg_addr)
				`ID_STOP_BEHAVIOUR: rdata_ff <= {15'h0, stop_mode_ff};
				`ID_BRAKE_FUNCTION: rdata_ff <= {14'h0, brake_fn_ff};
				`ID_BRAKE_DURATION: rdata_ff <= brake_dur_ff;
				`ID_BRAKE_VOLTAGE: rdata_ff <= brake_pct_ff;
				`ID_BRAKE_ACT_FREQ: rdata_ff <= act_freq_ff;
				default: rdata_ff <= 16'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clamps: stored value kept as written, clamped copy used
	assign dur_clamped = (brake_dur_ff > `BRAKE_TIME_MAX_TENTHS) ?
		`BRAKE_TIME_MAX_TENTHS : brake_dur_ff;
	assign pct_clamped = (brake_pct_ff > `BRAKE_PCT_MAX) ? `BRAKE_PCT_MAX : brake_pct_ff;
	assign act_clamped = (act_freq_ff > max_frequency) ? max_frequency : act_freq_ff;
	assign volt_prod = 32'(rated_voltage) * 32'(pct_clamped);

	// function decode
	assign brake_on_stop = brake_fn_ff[`FN_ON_STOP_BIT];
	assign brake_pre_start = brake_fn_ff[`FN_BEFORE_START_BIT];

	// brake voltage registered so the output stage sees a clean word
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			bvolt_ff <= 16'h0;
		else
			bvolt_ff <= 16'(volt_prod / `PCT_DIVISOR);
	end

	////////////////////////////////////////////////////////////////////////
	// ramp pacing: one frequency step per RAMP_CYCLES
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			ramp_cnt_ff <= 16'h0;
		else if (ramp_tick)
			ramp_cnt_ff <= 16'h0;
		else
			ramp_cnt_ff <= ramp_cnt_ff + 16'h1;
	end

	assign ramp_tick = (ramp_cnt_ff == 16'(RAMP_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////
	// next state; stop brake runs to its end even if run returns,
	// so a restart never fights a motor still being held
	always_comb
	begin
		nxt_state = state_ff;
		start_timer = 1'b0;
		unique case (state_ff)
			ST_IDLE:
			begin
				if (run_cmd && brake_pre_start)
				begin
					nxt_state = ST_PRE_BRAKE;
					start_timer = 1'b1;
				end
				else if (run_cmd)
					nxt_state = ST_RUN;
			end
			ST_PRE_BRAKE:
			begin
				if (tif.done)
					nxt_state = ST_RUN;
			end
			ST_RUN, ST_RAMP:
			begin
				if (run_cmd)
					nxt_state = ST_RUN;
				else if (stop_mode_ff == STOP_COAST)
				begin
					if (brake_on_stop)
					begin
						nxt_state = ST_STOP_BRAKE;
						start_timer = 1'b1;
					end
					else
						nxt_state = ST_IDLE;
				end
				else if (brake_on_stop && freq_ff <= act_clamped)
				begin
					nxt_state = ST_STOP_BRAKE;
					start_timer = 1'b1;
				end
				else if (!brake_on_stop && freq_ff == 16'h0)
					nxt_state = ST_IDLE;
				else
					nxt_state = ST_RAMP;
			end
			ST_STOP_BRAKE:
			begin
				if (tif.done)
					nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	assign tif.start = start_timer;
	assign tif.tenths = dur_clamped;

	////////////////////////////////////////////////////////////////////////
	// output frequency: ramps toward setpoint in run, to zero in ramp
	always_comb
	begin
		nxt_freq = freq_ff;
		if (nxt_state == ST_RUN && ramp_tick)
		begin
			if (freq_ff < set_frequency && freq_ff < max_frequency)
				nxt_freq = freq_ff + 16'h1;
			else if (freq_ff > set_frequency)
				nxt_freq = freq_ff - 16'h1;
		end
		else if (nxt_state == ST_RAMP)
		begin
			if (ramp_tick && freq_ff != 16'h0)
				nxt_freq = freq_ff - 16'h1;
		end
		else if (nxt_state != ST_RUN)
			nxt_freq = 16'h0;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			freq_ff <= 16'h0;
		else
			freq_ff <= nxt_freq;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign dc_inject = (state_ff == ST_PRE_BRAKE) || (state_ff == ST_STOP_BRAKE);
	assign output_on = (state_ff != ST_IDLE);
	assign out_frequency = freq_ff;
	assign brake_voltage = dc_inject ? bvolt_ff : 16'h0;
	assign seq_state = state_ff;
	assign reg_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_coast_stop;
		(state_ff == ST_RUN) && !run_cmd && (stop_mode_ff == STOP_COAST);
	endsequence

	property p_inject_dc;
		@(posedge mclk) disable iff (sys_rst)
		dc_inject |-> (out_frequency == 16'h0) && (brake_voltage == bvolt_ff);
	endproperty
	a_inject_dc: assert property (p_inject_dc) else $error("brake not dc");

	property p_dur_limit;
		@(posedge mclk) disable iff (sys_rst)
		start_timer |-> tif.tenths <= `BRAKE_TIME_MAX_TENTHS;
	endproperty
	a_dur_limit: assert property (p_dur_limit) else $error("duration over limit");

	property p_volt_pct;
		@(posedge mclk) disable iff (sys_rst)
		$stable(rated_voltage) && $stable(pct_clamped) |=>
			bvolt_ff <= rated_voltage;
	endproperty
	a_volt_pct: assert property (p_volt_pct) else $error("brake voltage too high");

	property p_ramp_brake;
		@(posedge mclk) disable iff (sys_rst)
		(state_ff == ST_RAMP) && !run_cmd && brake_on_stop &&
			(freq_ff <= act_clamped) |=> (state_ff == ST_STOP_BRAKE);
	endproperty
	a_ramp_brake: assert property (p_ramp_brake) else $error("no brake at freq");

	property p_coast_brake;
		@(posedge mclk) disable iff (sys_rst)
		s_coast_stop and (brake_on_stop == 1'b1) |=> (state_ff == ST_STOP_BRAKE);
	endproperty
	a_coast_brake: assert property (p_coast_brake) else $error("coast no brake");

	property p_coast_free;
		@(posedge mclk) disable iff (sys_rst)
		s_coast_stop and (brake_on_stop == 1'b0) |=> !output_on ##1 !output_on;
	endproperty
	a_coast_free: assert property (p_coast_free) else $error("coast kept output");

	property p_fn_off;
		@(posedge mclk) disable iff (sys_rst)
		(state_ff == ST_IDLE) && run_cmd && (brake_fn_ff == 2'h0) |=>
			(state_ff == ST_RUN);
	endproperty
	a_fn_off: assert property (p_fn_off) else $error("brake while disabled");

	property p_pre_start;
		@(posedge mclk) disable iff (sys_rst)
		(state_ff == ST_IDLE) && run_cmd && brake_pre_start |=>
			dc_inject && tif.busy;
	endproperty
	a_pre_start: assert property (p_pre_start) else $error("no brake before start");

	property p_act_limit;
		@(posedge mclk) disable iff (sys_rst)
		act_clamped <= max_frequency;
	endproperty
	a_act_limit: assert property (p_act_limit) else $error("act freq over max");

	property p_brake_end;
		@(posedge mclk) disable iff (sys_rst)
		(state_ff == ST_STOP_BRAKE) && tif.done |=> !output_on && !dc_inject;
	endproperty
	a_brake_end: assert property (p_brake_end) else $error("output after brake");

endmodule : dc_brake_seq

// File: testbench/motor_model.sv
/*
 * behavioural three-phase motor as seen from the drive output stage.
 * assumes the sequencer outputs change on the same mclk; a load keeps
 * the shaft turning before the first start.
 */
`timescale 1ns/100ps
module motor_model (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// drive output stage
	input wire logic output_on,
	input wire logic dc_inject,
	input wire logic [15:0] out_frequency,
	input wire logic [15:0] brake_voltage,
	// shaft
	output logic [15:0] speed_ff
);
	////////////////////////////////////////////////////////////////////////
	// shaft speed; no friction, so only a dc field or the drive changes it
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			speed_ff <= 16'h0020; // already spinning, driven by the load
		else if (output_on && dc_inject && (brake_voltage != 16'h0000))
			speed_ff <= speed_ff >> 1; // dc field brakes the rotor
		else if (output_on && !dc_inject)
			speed_ff <= out_frequency; // rotor follows the rotating field
	end
endmodule : motor_model

// File: testbench/tb.sv
/*
 * self-checking bench for the dc brake and stop sequencer.
 * assumes short tick and ramp counts; inputs change on the falling edge.
 */
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
	begin \
		check_count++; \
		if ((exp) !== (got)) \
		begin \
			failures++; \
			$display("mismatch %s expected %h seen %h", nm, exp, got); \
		end \
	end
module tb;
	import dc_brake_pkg::*;
	logic mclk, sys_rst, run_clockwise, run_counterclockwise, reg_wr;
	logic [15:0] rated_voltage, max_frequency, set_frequency, reg_wdata, reg_rdata;
	logic [7:0] reg_addr;
	logic output_on, dc_inject; // output stage
	logic [15:0] out_frequency, brake_voltage, speed;
	logic [2:0] seq_state;
	int failures = 0; // mismatches seen
	int check_count = 0; // comparisons made

	// short tick so a tenth of a second is four cycles
	dc_brake_seq #(.TICK_CYCLES(4), .RAMP_CYCLES(2)) dc_brake_seq_i (.mclk(mclk),
		.sys_rst(sys_rst), .run_clockwise(run_clockwise),
		.run_counterclockwise(run_counterclockwise), .rated_voltage(rated_voltage),
		.max_frequency(max_frequency), .set_frequency(set_frequency),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .output_on(output_on), .dc_inject(dc_inject),
		.out_frequency(out_frequency), .brake_voltage(brake_voltage),
		.seq_state(seq_state));
	motor_model motor_model_i (.mclk(mclk), .sys_rst(sys_rst), .output_on(output_on),
		.dc_inject(dc_inject), .out_frequency(out_frequency),
		.brake_voltage(brake_voltage), .speed_ff(speed));

	always #50 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////
	// report counts and end the run
	task automatic stop_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// a bounded wait that runs out is a mismatch and ends the run
	task automatic give_up(input string nm);
		failures++;
		$display("mismatch %s expected done seen timeout", nm);
		stop_test();
	endtask : give_up

	// bounded wait for an output frequency
	task automatic wait_freq(input logic [15:0] f);
		int i;
		for (i = 0; i < 200 && out_frequency !== f; i++)
			@(negedge mclk);
		if (out_frequency !== f)
			give_up("wait_freq");
	endtask : wait_freq

	// one write; an extra edge keeps back to back strobes apart
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		@(negedge mclk);
	endtask : wr

	// read data is registered, so it is valid one cycle after the address
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
		reg_addr = a;
		@(negedge mclk);
		`CHK(nm, e, reg_rdata)
	endtask : rd

	task automatic run_set(input logic cw, input logic ccw);
		run_clockwise = cw;
		run_counterclockwise = ccw;
		@(negedge mclk);
	endtask : run_set

	// bounded wait for a sequencer state; a hang ends the run
	task automatic wait_st(input logic [2:0] st);
		int i;
		for (i = 0; i < 2000 && seq_state !== st; i++)
			@(negedge mclk);
		if (seq_state !== st)
		begin
			failures++;
			$display("mismatch wait_state expected %h seen %h", st, seq_state);
			stop_test();
		end
	endtask : wait_st

	// cycles spent in a state from now on
	task automatic cnt_st(input logic [2:0] st, output int n);
		n = 0;
		while (seq_state === st && n < 2000)
		begin
			n++;
			@(negedge mclk);
		end
		if (n >= 2000)
			give_up("cnt_state");
	endtask : cnt_st

	////////////////////////////////////////////////////////////////////////
	// reset values, unmapped id, stored widths, run interlock
	task automatic s_regs;
		rd(8'h85, 16'h0001, "stop_rst");
		rd(8'h99, 16'h0000, "fn_rst");
		rd(8'h9a, 16'h0000, "dur_rst");
		rd(8'h9b, 16'h0000, "pct_rst");
		rd(8'h9c, 16'h0000, "act_rst");
		wr(8'h40, 16'h1234);
		rd(8'h40, 16'h0000, "unmapped");
		wr(8'h85, 16'h0002);
		rd(8'h85, 16'h0000, "stop_bit0");
		run_set(1'b1, 1'b1);
		repeat (6) @(negedge mclk);
		`CHK("interlock", ST_IDLE, seq_state)
		run_set(1'b0, 1'b0);
	endtask : s_regs

	// brake before start halts the spinning shaft, then runs
	task automatic s_pre;
		int n;
		wr(8'h99, 16'h0002);
		wr(8'h9a, 16'h0002);
		wr(8'h9b, 16'h0032);
		run_set(1'b1, 1'b0);
		wait_st(ST_PRE_BRAKE);
		@(negedge mclk);
		`CHK("pre_inject", 1'b1, dc_inject)
		`CHK("pre_volt", 16'h00c8, brake_voltage)
		cnt_st(ST_PRE_BRAKE, n);
		`CHK("pre_len", 1'b1, n >= 7 && n <= 11)
		`CHK("pre_stopped", 16'h0000, speed)
		`CHK("pre_then_run", ST_RUN, seq_state)
		run_set(1'b0, 1'b0);
		repeat (2) @(negedge mclk);
		`CHK("no_stop_brake", ST_IDLE, seq_state)
	endtask : s_pre

	// ramp stop switches to dc at the activation frequency
	task automatic s_ramp;
		int n;
		logic [15:0] last;
		wr(8'h85, 16'h0001);
		wr(8'h99, 16'h0001);
		wr(8'h9a, 16'h0001);
		wr(8'h9c, 16'h0005);
		run_set(1'b0, 1'b1);
		wait_st(ST_RUN);
		wait_freq(16'h000a);
		`CHK("run_freq", 16'h000a, out_frequency)
		run_set(1'b0, 1'b0);
		repeat (2) @(negedge mclk);
		`CHK("ramp_mode", ST_RAMP, seq_state)
		last = out_frequency;
		for (n = 0; n < 200 && seq_state !== ST_STOP_BRAKE; n++)
		begin
			last = out_frequency;
			@(negedge mclk);
		end
		if (seq_state !== ST_STOP_BRAKE)
			give_up("wait_brake");
		`CHK("brake_at", 1'b1, last >= 16'h0004 && last <= 16'h0005)
		`CHK("brake_freq0", 16'h0000, out_frequency)
		cnt_st(ST_STOP_BRAKE, n);
		`CHK("stop_len", 1'b1, n >= 4 && n <= 8)
		`CHK("off_state", ST_IDLE, seq_state)
		`CHK("off_out", 1'b0, output_on)
		`CHK("shaft_still", 16'h0000, speed)
	endtask : s_ramp

	// every function code in coast mode; coast brakes at once
	task automatic s_fn_table;
		wr(8'h85, 16'h0000);
		wr(8'h9c, 16'h0000);
		for (int f = 0; f < 4; f++)
		begin
			wr(8'h99, 16'(f));
			run_set(1'b1, 1'b0);
			repeat (2) @(negedge mclk);
			`CHK("pre_sel", f[1] ? ST_PRE_BRAKE : ST_RUN, seq_state)
			wait_st(ST_RUN);
			run_set(1'b0, 1'b0);
			repeat (2) @(negedge mclk);
			`CHK("stop_sel", f[0] ? ST_STOP_BRAKE : ST_IDLE, seq_state)
			wait_st(ST_IDLE);
		end
	endtask : s_fn_table

	// duration and percent beyond their limits are clamped
	task automatic s_clamp;
		int n;
		wr(8'h99, 16'h0001);
		wr(8'h9a, 16'h00c8);
		wr(8'h9b, 16'h0096);
		rd(8'h9a, 16'h00c8, "dur_raw");
		run_set(1'b1, 1'b0);
		wait_st(ST_RUN);
		run_set(1'b0, 1'b0);
		wait_st(ST_STOP_BRAKE);
		@(negedge mclk);
		`CHK("volt_clamp", 16'h0190, brake_voltage)
		cnt_st(ST_STOP_BRAKE, n);
		`CHK("dur_clamp", 1'b1, n >= 399 && n <= 404)
	endtask : s_clamp

	// ramp stop without stop braking runs down to zero, then idles
	task automatic s_ramp_free;
		int n;
		wr(8'h85, 16'h0001);
		wr(8'h99, 16'h0000);
		run_set(1'b1, 1'b0);
		wait_st(ST_RUN);
		wait_freq(16'h000a);
		run_set(1'b0, 1'b0);
		repeat (2) @(negedge mclk);
		cnt_st(ST_RAMP, n);
		`CHK("ramp_len", 1'b1, n >= 18 && n <= 21)
		`CHK("ramp_end", ST_IDLE, seq_state)
		`CHK("ramp_zero", 16'h0000, out_frequency)
		`CHK("no_dc_volt", 16'h0000, brake_voltage)
	endtask : s_ramp_free

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		run_clockwise = 1'b0;
		run_counterclockwise = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		rated_voltage = 16'h0190;
		max_frequency = 16'h0064;
		set_frequency = 16'h000a;
		repeat (12) @(negedge mclk);
		sys_rst = 1'b0;
		@(negedge mclk);
		s_regs();
		s_pre();
		s_ramp();
		s_fn_table();
		s_clamp();
		s_ramp_free();
		stop_test();
	end
endmodule : tb
